/* File: olsc_pkg.sv */
package olsc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Command codes
  localparam logic [7:0] CMD_CLEAR     = 8'h03;
  localparam logic [7:0] CMD_VOUT_MODE = 8'h20;
  localparam logic [7:0] CMD_STAT_WORD = 8'h79;
  localparam logic [7:0] CMD_STAT_VOUT = 8'h7A;
  localparam logic [7:0] CMD_STAT_IOUT = 8'h7B;
  localparam logic [7:0] CMD_STAT_CML  = 8'h7E;
  localparam logic [7:0] CMD_FCEIL     = 8'hA5;
  localparam logic [7:0] CMD_COMMON    = 8'hEF;

  // Storage slots, their command codes and reset words
  localparam int NSLOT    = 22;
  localparam int S_VCMD   = 0;
  localparam int S_CEIL   = 1;
  localparam int S_LLP    = 2;
  localparam int S_MHI    = 3;
  localparam int S_MLO    = 4;
  localparam int S_OVF    = 5;
  localparam int S_OVW    = 6;
  localparam int S_UVW    = 7;
  localparam int S_UVF    = 8;
  localparam int S_RSNS   = 10;
  localparam int S_OCF    = 11;
  localparam int S_OCW    = 12;
  localparam int S_TEMPCO = 20;
  localparam int S_MASK   = 21;
  localparam logic [7:0] SLOT_CMD [NSLOT] = '{
    8'h21, 8'h24, 8'hD3, 8'h25, 8'h26, 8'h40, 8'h42, 8'h43, 8'h44, 8'h27, 8'h38,
    8'h46, 8'h4A, 8'h60, 8'h61, 8'h62, 8'h64, 8'h65, 8'h66, 8'hDC, 8'hF6, 8'hF0};
  localparam logic [15:0] SLOT_RST [NSLOT] = '{
    16'h1000, 16'h5800, 16'h8000, 16'h10CD, 16'h0F33, 16'h119A, 16'h1133,
    16'h0ECD, 16'h0E66, 16'hAA00, 16'hB285, 16'hDBB8, 16'hDA80, 16'h8000,
    16'hD200, 16'hD280, 16'h8000, 16'hD200, 16'hF258, 16'hFBE8, 16'h0F3C,
    16'h0000};

  // Fixed words
  localparam logic [15:0] FCEIL_VAL   = 16'h599A;
  localparam logic [7:0]  VOUT_MODE_V = 8'h14;
  localparam logic [15:0] RANGE0_LIM  = 16'h5800;
  localparam logic [15:0] RANGE1_LIM  = 16'h2C00;
  localparam logic [7:0]  COMMON_OK   = 8'h60;

  // Status bit positions
  localparam int SV_OVF  = 7;
  localparam int SV_OVW  = 6;
  localparam int SV_UVW  = 5;
  localparam int SV_UVF  = 4;
  localparam int SV_VMAX = 3;
  localparam int SI_OCF  = 7;
  localparam int SI_OCW  = 5;
  localparam int SC_DATA = 6;
  localparam int SW_VOUT = 15;
  localparam int SW_IOUT = 14;
  localparam int SW_CML  = 1;

  // Sense resistance arithmetic
  localparam longint TEMP_REF = 27;
  localparam longint TC_NUM   = 17180;
  localparam int     TC_SHIFT = 14;
  localparam int     FRAC_W   = 20;
  localparam logic [7:0] OC_CODE_MAX = 8'hC8;

  // Link frame bit counts
  localparam logic [5:0] FR_CMD_END = 6'h08;
  localparam logic [5:0] FR_WR_END  = 6'h18;
  localparam logic [5:0] FR_RD_END  = 6'h28;

  // Timing
  localparam int CORE_HZ       = 20000000;
  localparam int OV_SETTLE_MS  = 10;
  localparam int OV_SETTLE_DEF = CORE_HZ / 1000 * OV_SETTLE_MS;
  localparam int SETTLE_W      = 18;

  // Request passed from the link to the core
  typedef struct packed {
    logic        rd;
    logic [7:0]  cmd;
    logic [15:0] data;
  } olsc_req_t;

endpackage

/* File: olsc_top.sv */
`timescale 1ns/1ps
// Operation
// - Read-only word returns factory voltage ceiling
// - Ceiling above factory value: fault, store factory
// - Warn when ceiling exceeds range limit
// - Clamp any requested output to ceiling, warn
// - Warning overwrites command, sets status, raises alert
// - Load line uses warning current as full scale
// - Nonzero load line disables servo mode
// - Zero load line disables positioning
// - Common bits 6:5 low while limit settles
// - Overvoltage warning sets status and alert
// - Undervoltage warning sets status and alert
// - Overvoltage fault above trip level
// - Undervoltage fault below trip level
// - Effective resistance follows temperature coefficient formula
// - Tempco word is signed two's complement
// - Trip current to 0.4mV steps, 0..80mV
// - Overcurrent faults ignored during ramps
// - Overcurrent warning outside ramps sets status, alert
// - Voltage words linear, exponent minus twelve
module olsc_top
  import olsc_pkg::*;
#(
  parameter int OV_SETTLE_CYC = OV_SETTLE_DEF
) (
  // Clock and reset
  input  wire logic        core_clk_in,
  input  wire logic        nrst_in,
  // Serial command link
  input  wire logic        link_clk_in,
  input  wire logic        frame_n_in,
  input  wire logic        sdi_in,
  output logic             sdo_out,
  output logic             sdo_oe_out,
  // Open-drain alert
  output logic             alert_out,
  output logic             alert_oe_out,
  // Channel measurements and state
  input  wire logic [15:0] vsense_in,
  input  wire logic [15:0] iout_in,
  input  wire logic [7:0]  isense_in,
  input  wire logic [15:0] temp_in,
  input  wire logic        rise_ramp_in,
  input  wire logic        fall_ramp_in,
  input  wire logic        chan_on_in,
  input  wire logic        margin_hi_in,
  input  wire logic        margin_lo_in,
  input  wire logic        range_sel_in,
  input  wire logic        servo_req_in,
  // Regulation outputs
  output logic [15:0]      vout_target_out,
  output logic             servo_on_out,
  output logic             llp_on_out,
  output logic [15:0]      llp_pct_out,
  output logic [15:0]      llp_full_scale_out,
  output logic [15:0]      rsense_out,
  output logic [7:0]       oc_code_out,
  output logic             ov_fault_out,
  output logic             uv_fault_out,
  output logic             oc_fault_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Helper functions

  // Slot lookup: bit 5 set on a hit, low bits give the index
  function automatic logic [5:0] slot_of(input logic [7:0] cmd);
    slot_of = 6'h00;
    for (int i = 0; i < NSLOT; i++) begin
      if (SLOT_CMD[i] == cmd) begin
        slot_of = {1'b1, 5'(i)};
      end
    end
  endfunction

  // Signed 5/11 linear word to fixed point with 16 fraction bits
  function automatic logic signed [47:0] l11_fix(input logic [15:0] w);
    logic signed [47:0] m;
    m = 48'(signed'(w[10:0]));
    l11_fix = m <<< {~w[15], w[14:11]};
  endfunction

  // Trip current times resistance, in 0.4mV steps, rounded and limited
  function automatic logic [7:0] oc_code(input logic [15:0] lim,
                                         input logic [15:0] rs);
    logic signed [31:0] p;
    logic signed [6:0]  e;
    logic signed [31:0] r;
    p = 32'(signed'(lim[10:0])) * 32'(signed'(rs[10:0])) * 32'sh5;
    e = 7'(signed'(lim[15:11])) + 7'(signed'(rs[15:11])) - 7'sh1;
    if (p <= 32'sh0) begin
      r = 32'sh0;
    end else if (e >= 7'sh0) begin
      r = 32'(OC_CODE_MAX);
    end else begin
      r = (p + (32'sh1 <<< (-e - 7'sh1))) >>> (-e);
    end
    oc_code = (r > 32'(OC_CODE_MAX)) ? OC_CODE_MAX : r[7:0];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Link domain: frame shifter

  logic             link_arst_n;
  logic [5:0]       cnt_ff;
  logic [24:0]      sh_ff;
  logic [24:0]      nxt_sh;
  logic [15:0]      out_ff;
  logic             oe_ff;
  logic             rd_frame_ff;
  olsc_req_t        req_ff;
  logic             req_tgl_ff;
  logic [15:0]      rd_word_ff;

  // Frame end clears the shifter without needing a link edge
  assign link_arst_n = nrst_in & ~frame_n_in;
  assign nxt_sh      = {sh_ff[23:0], sdi_in};

  // Bit counter and input shift register
  always_ff @(posedge link_clk_in or negedge link_arst_n) begin
    if (!link_arst_n) begin
      cnt_ff <= 6'h00;
      sh_ff  <= '0;
    end else begin
      cnt_ff <= (cnt_ff == 6'h3F) ? cnt_ff : cnt_ff + 6'h01;
      sh_ff  <= nxt_sh;
    end
  end

  // Read data shifter, driven after the turnaround gap
  always_ff @(posedge link_clk_in or negedge link_arst_n) begin
    if (!link_arst_n) begin
      out_ff      <= 16'h0000;
      oe_ff       <= 1'b0;
      rd_frame_ff <= 1'b0;
    end else begin
      if (cnt_ff == FR_CMD_END) begin
        rd_frame_ff <= nxt_sh[8];
      end
      if (cnt_ff == FR_WR_END) begin
        out_ff <= rd_word_ff;
        oe_ff  <= rd_frame_ff;
      end else if (cnt_ff == FR_RD_END) begin
        oe_ff <= 1'b0;
      end else begin
        out_ff <= {out_ff[14:0], 1'b0};
      end
    end
  end

  // Finished requests held stable and flagged by a toggle
  always_ff @(posedge link_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      req_ff     <= '0;
      req_tgl_ff <= 1'b0;
    end else if (cnt_ff == FR_CMD_END && nxt_sh[8]) begin
      req_ff     <= '{rd: 1'b1, cmd: nxt_sh[7:0], data: 16'h0000};
      req_tgl_ff <= ~req_tgl_ff;
    end else if (cnt_ff == FR_WR_END && !rd_frame_ff) begin
      req_ff     <= '{rd: 1'b0, cmd: nxt_sh[23:16], data: nxt_sh[15:0]};
      req_tgl_ff <= ~req_tgl_ff;
    end
  end

  assign sdo_out    = out_ff[15];
  assign sdo_oe_out = oe_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Core domain: request crossing

  logic      tg1_ff;
  logic      tg2_ff;
  logic      tg3_ff;
  logic      seen_ff;
  logic      req_ev;
  logic      go_ff;
  olsc_req_t cur_ff;

  // Toggle counts once the second and third stages agree
  assign req_ev = (tg2_ff == tg3_ff) && (tg3_ff != seen_ff);

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      tg1_ff  <= 1'b0;
      tg2_ff  <= 1'b0;
      tg3_ff  <= 1'b0;
      seen_ff <= 1'b0;
      go_ff   <= 1'b0;
      cur_ff  <= '0;
    end else begin
      tg1_ff <= req_tgl_ff;
      tg2_ff <= tg1_ff;
      tg3_ff <= tg2_ff;
      go_ff  <= req_ev;
      if (req_ev) begin
        seen_ff <= tg3_ff;
        cur_ff  <= req_ff;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command storage

  logic [15:0] regs_ff [NSLOT];
  logic [5:0]  wslot;
  logic [4:0]  widx;
  logic        wr_go;
  logic        whit;
  logic        vslot;
  logic [4:0]  sel_slot;
  logic [15:0] sel_val;
  logic [15:0] ceil;
  logic        over;

  assign wslot = slot_of(cur_ff.cmd);
  assign widx  = wslot[4:0];
  assign whit  = wslot[5];
  assign wr_go = go_ff & ~cur_ff.rd;
  assign ceil  = regs_ff[S_CEIL];
  assign vslot = (widx == 5'(S_VCMD)) || (widx == 5'(S_MHI)) || (widx == 5'(S_MLO));

  // Voltage source chosen by the margin state
  always_comb begin
    sel_slot = 5'(S_VCMD);
    if (margin_hi_in) begin
      sel_slot = 5'(S_MHI);
    end else if (margin_lo_in) begin
      sel_slot = 5'(S_MLO);
    end
  end
  assign sel_val = regs_ff[sel_slot];
  assign over    = sel_val > ceil;

  // Writes, with ceiling checks on the voltage words
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      for (int i = 0; i < NSLOT; i++) begin
        regs_ff[i] <= SLOT_RST[i];
      end
    end else if (wr_go && whit) begin
      if (widx == 5'(S_CEIL) && cur_ff.data > FCEIL_VAL) begin
        regs_ff[widx] <= FCEIL_VAL;
      end else if (vslot && cur_ff.data > ceil) begin
        regs_ff[widx] <= ceil;
      end else begin
        regs_ff[widx] <= cur_ff.data;
      end
    end else if (over) begin
      regs_ff[sel_slot] <= ceil;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sense resistance and trip code

  logic signed [63:0] tc_prod;
  logic signed [63:0] factor;
  logic signed [63:0] rmul;
  logic [15:0]        rsense_ff;
  logic [7:0]         oc_code_ff;

  // Gain scaled by one plus tempco times temperature rise, ppm units
  always_comb begin
    tc_prod = 64'(signed'(regs_ff[S_TEMPCO])) *
              (64'(signed'(temp_in)) - TEMP_REF);
    factor  = (64'sh1 <<< FRAC_W) + ((tc_prod * TC_NUM) >>> TC_SHIFT);
    rmul    = (64'(signed'(regs_ff[S_RSNS][10:0])) * factor) >>> FRAC_W;
  end

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rsense_ff  <= 16'h0000;
      oc_code_ff <= 8'h00;
    end else begin
      rsense_ff  <= {regs_ff[S_RSNS][15:11], rmul[10:0]};
      oc_code_ff <= oc_code(regs_ff[S_OCF], rsense_ff);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Supervisors and status

  logic       ramp;
  logic [7:0] vset;
  logic [7:0] iset;
  logic [7:0] vclr;
  logic [7:0] iclr;
  logic       cml_set;
  logic       cml_clr;
  logic [7:0] stat_v_ff;
  logic [7:0] stat_i_ff;
  logic       cml_ff;
  logic [2:0] flt_ff;
  logic       wr_ro;
  logic       wr_stat;
  logic [15:0] mask;

  assign ramp    = rise_ramp_in | fall_ramp_in;
  assign mask    = regs_ff[S_MASK];
  assign wr_stat = (cur_ff.cmd == CMD_STAT_VOUT) || (cur_ff.cmd == CMD_STAT_IOUT) ||
                   (cur_ff.cmd == CMD_STAT_CML) || (cur_ff.cmd == CMD_CLEAR);
  assign wr_ro   = wr_go && !whit && !wr_stat;

  // Event sources for the sticky status bits
  always_comb begin
    vset          = 8'h00;
    iset          = 8'h00;
    vset[SV_OVF]  = vsense_in > regs_ff[S_OVF];
    vset[SV_OVW]  = vsense_in > regs_ff[S_OVW];
    vset[SV_UVW]  = chan_on_in && vsense_in < regs_ff[S_UVW];
    vset[SV_UVF]  = chan_on_in && vsense_in < regs_ff[S_UVF];
    vset[SV_VMAX] = over || (wr_go && vslot && whit && cur_ff.data > ceil) ||
                    (wr_go && widx == 5'(S_CEIL) && whit &&
                     cur_ff.data > (range_sel_in ? RANGE1_LIM : RANGE0_LIM));
    iset[SI_OCF]  = !ramp && isense_in > oc_code_ff;
    iset[SI_OCW]  = !ramp && l11_fix(iout_in) > l11_fix(regs_ff[S_OCW]);
    cml_set       = wr_ro ||
                    (wr_go && whit && widx == 5'(S_CEIL) && cur_ff.data > FCEIL_VAL);
  end

  // Clears from status writes of ones or the clear command
  always_comb begin
    vclr    = 8'h00;
    iclr    = 8'h00;
    cml_clr = 1'b0;
    if (wr_go) begin
      if (cur_ff.cmd == CMD_CLEAR) begin
        vclr    = 8'hFF;
        iclr    = 8'hFF;
        cml_clr = 1'b1;
      end else if (cur_ff.cmd == CMD_STAT_VOUT) begin
        vclr = cur_ff.data[7:0];
      end else if (cur_ff.cmd == CMD_STAT_IOUT) begin
        iclr = cur_ff.data[7:0];
      end else if (cur_ff.cmd == CMD_STAT_CML) begin
        cml_clr = cur_ff.data[SC_DATA];
      end
    end
  end

  // Sticky bits, a new event wins over a clear
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      stat_v_ff <= 8'h00;
      stat_i_ff <= 8'h00;
      cml_ff    <= 1'b0;
    end else begin
      stat_v_ff <= (stat_v_ff & ~vclr) | vset;
      stat_i_ff <= (stat_i_ff & ~iclr) | iset;
      cml_ff    <= (cml_ff & ~cml_clr) | cml_set;
    end
  end

  // Live fault levels and the alert line
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      flt_ff       <= 3'b000;
      alert_oe_out <= 1'b0;
    end else begin
      flt_ff       <= {iset[SI_OCF], vset[SV_UVF], vset[SV_OVF]};
      alert_oe_out <= |(stat_v_ff & ~mask[7:0]) | |(stat_i_ff & ~mask[15:8]) |
                      cml_ff;
    end
  end

  assign alert_out    = 1'b0;
  assign ov_fault_out = flt_ff[0];
  assign uv_fault_out = flt_ff[1];
  assign oc_fault_out = flt_ff[2];

  ////////////////////////////////////////////////////////////////////////////
  // Overvoltage limit settling

  logic [SETTLE_W-1:0] settle_ff;

  // Counts down after a trip level write while the channel runs
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      settle_ff <= '0;
    end else if (wr_go && whit && widx == 5'(S_OVF) && chan_on_in) begin
      settle_ff <= SETTLE_W'(OV_SETTLE_CYC);
    end else if (settle_ff != '0) begin
      settle_ff <= settle_ff - 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read answers and regulation outputs

  logic [15:0] rd_sel;
  logic [7:0]  common;

  assign common = (settle_ff != '0) ? 8'h00 : COMMON_OK;

  // Word returned for a read command
  always_comb begin
    rd_sel = 16'h0000;
    if (whit) begin
      rd_sel = regs_ff[widx];
    end
    case (cur_ff.cmd)
      CMD_VOUT_MODE: rd_sel = {8'h00, VOUT_MODE_V};
      CMD_FCEIL:     rd_sel = FCEIL_VAL;
      CMD_STAT_VOUT: rd_sel = {8'h00, stat_v_ff};
      CMD_STAT_IOUT: rd_sel = {8'h00, stat_i_ff};
      CMD_STAT_CML:  rd_sel = 16'(cml_ff) << SC_DATA;
      CMD_COMMON:    rd_sel = {8'h00, common};
      CMD_STAT_WORD: begin
        rd_sel          = 16'h0000;
        rd_sel[SW_VOUT] = |stat_v_ff;
        rd_sel[SW_IOUT] = |stat_i_ff;
        rd_sel[SW_CML]  = cml_ff;
      end
      default: ;
    endcase
  end

  // Read word capture and regulation targets
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rd_word_ff         <= 16'h0000;
      vout_target_out    <= 16'h0000;
      servo_on_out       <= 1'b0;
      llp_on_out         <= 1'b0;
      llp_pct_out        <= 16'h0000;
      llp_full_scale_out <= 16'h0000;
      rsense_out         <= 16'h0000;
      oc_code_out        <= 8'h00;
    end else begin
      if (go_ff && cur_ff.rd) begin
        rd_word_ff <= rd_sel;
      end
      vout_target_out    <= over ? ceil : sel_val;
      llp_on_out         <= regs_ff[S_LLP][10:0] != 11'h000;
      servo_on_out       <= servo_req_in &&
                            regs_ff[S_LLP][10:0] == 11'h000;
      llp_pct_out        <= regs_ff[S_LLP];
      llp_full_scale_out <= regs_ff[S_OCW];
      rsense_out         <= rsense_ff;
      oc_code_out        <= oc_code_ff;
    end
  end

endmodule

/* File: olsc_top_properties.sv */
`timescale 1ns/1ps
module olsc_top_properties
  import olsc_pkg::*;
(
  // Clock and reset
  input wire logic        core_clk_in,
  input wire logic        nrst_in,
  // Channel state
  input wire logic        servo_req_in,
  input wire logic        rise_ramp_in,
  input wire logic        fall_ramp_in,
  input wire logic        chan_on_in,
  // Watched outputs
  input wire logic        alert_out,
  input wire logic [15:0] vout_target_out,
  input wire logic        servo_on_out,
  input wire logic        llp_on_out,
  input wire logic [15:0] llp_pct_out,
  input wire logic [7:0]  oc_code_out,
  input wire logic        uv_fault_out,
  input wire logic        oc_fault_out
);
  ////////////////////////////////////////////////////////////////////////////
  // Core domain defaults
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!nrst_in);

  // Target never exceeds the hard ceiling
  a_target_ceiling: assert property (vout_target_out <= FCEIL_VAL)
    else $error("target above ceiling");
  // Servo and load line exclude each other
  a_servo_excl: assert property (servo_on_out |-> !llp_on_out)
    else $error("servo on with load line");
  // Positioning flag follows the mantissa of the percent word
  a_llp_flag: assert property (llp_on_out == (llp_pct_out[10:0] != 11'h000))
    else $error("load line flag wrong");
  // Servo needs a request
  a_servo_cause: assert property (servo_on_out |-> $past(servo_req_in))
    else $error("servo without request");
  // Ramps hide overcurrent faults
  a_oc_ramp_mask: assert property ((rise_ramp_in || fall_ramp_in) [*3] |-> !oc_fault_out)
    else $error("overcurrent fault during ramp");
  // Trip code stays in range
  a_oc_code_max: assert property (oc_code_out <= OC_CODE_MAX)
    else $error("trip code out of range");
  // Undervoltage only while channel on
  a_uv_chan_on: assert property (uv_fault_out |-> $past(chan_on_in))
    else $error("undervoltage while off");
  // Alert pin is open drain
  a_alert_pin: assert property (alert_out == 1'b0)
    else $error("alert pin driven high");
endmodule

bind olsc_top olsc_top_properties chk_u (.*);

/* File: olsc_host.sv */
`timescale 1ns/1ps
module olsc_host (
  // Link to device
  output logic      link_clk_out,
  output logic      frame_n_out,
  output logic      sdi_out,
  input  wire logic sdo_in
);
  localparam int HALF = 32;

  // Idle link, clock still
  initial begin
    link_clk_out = 1'b0;
    frame_n_out = 1'b1;
    sdi_out = 1'b0;
  end

  // Clocks with frame idle, only around reset
  task automatic idle(input int n);
    repeat (n) begin
      #HALF link_clk_out = 1'b1;
      #HALF link_clk_out = 1'b0;
    end
  endtask

  // One frame: read flag, command, then data or turnaround
  task automatic xfer(input logic rd, input logic [7:0] cmd, input logic [15:0] wd,
                      output logic [15:0] rdat);
    logic [24:0] bits;
    bits = {rd, cmd, rd ? 16'hA5A5 : wd};
    rdat = 16'h0000;
    frame_n_out = 1'b0;
    for (int i = 0; i < (rd ? 41 : 25); i++) begin
      sdi_out = (i < 25) ? bits[24-i] : ~sdi_out;
      #HALF link_clk_out = 1'b1;
      #HALF link_clk_out = 1'b0;
      if (rd && i >= 24 && i < 40) begin
        rdat = {rdat[14:0], sdo_in};
      end
    end
    #HALF frame_n_out = 1'b1;
    sdi_out = ~sdi_out;
    #(2*HALF);
  endtask
endmodule

/* File: olsc_top_tb.sv */
`timescale 1ns/1ps
module olsc_top_tb;
  import olsc_pkg::*;
  localparam int SETTLE = 2000;
  // Design pins
  logic        core_clk_in = 1'b0;
  logic        nrst_in = 1'b0;
  logic        link_clk_in, frame_n_in, sdi_in, sdo_out, sdo_oe_out;
  logic        alert_out, alert_oe_out, servo_on_out, llp_on_out;
  logic        ov_fault_out, uv_fault_out, oc_fault_out;
  logic        rise_ramp_in = 1'b0, fall_ramp_in = 1'b0, chan_on_in = 1'b1;
  logic        margin_hi_in = 1'b0, margin_lo_in = 1'b0;
  logic        range_sel_in = 1'b0, servo_req_in = 1'b1;
  logic [15:0] vsense_in = 16'h1000, iout_in = 16'hD000, temp_in = 16'h001B;
  logic [7:0]  isense_in = 8'h00;
  logic [15:0] vout_target_out, llp_pct_out, llp_full_scale_out, rsense_out;
  logic [7:0]  oc_code_out;
  int          n_errors = 0, check_count = 0, cyc = 0;

  olsc_top #(.OV_SETTLE_CYC(SETTLE)) dut_u (.*);
  olsc_host host_u (.link_clk_out(link_clk_in), .frame_n_out(frame_n_in),
                    .sdi_out(sdi_in), .sdo_in(sdo_out));

  // Core clock
  always #25 core_clk_in = ~core_clk_in;

  // Cycle limit against hangs
  always @(posedge core_clk_in) begin
    cyc++;
    if (cyc == 40000) begin
      n_errors++;
      finish_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Verdict and end of run
  task automatic finish_test();
    if (n_errors == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Compare and count
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  // Write, then let it cross
  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    logic [15:0] r;
    host_u.xfer(1'b0, c, d, r);
    repeat (10) @(negedge core_clk_in);
  endtask

  // Read and compare
  task automatic rd(input logic [7:0] c, input logic [15:0] e);
    logic [15:0] r;
    host_u.xfer(1'b1, c, 16'h0000, r);
    chk(r, e);
  endtask

  // Land on a falling edge after a few cycles
  task automatic settle();
    repeat (4) @(negedge core_clk_in);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Reset words and fixed words
  task automatic t_defaults();
    for (int s = 0; s < NSLOT; s++) rd(SLOT_CMD[s], SLOT_RST[s]);
    rd(CMD_VOUT_MODE, {8'h00, VOUT_MODE_V});
    rd(CMD_FCEIL, FCEIL_VAL);
    rd(8'hFE, 16'h0000);
    rd(CMD_STAT_VOUT, 16'h0000);
    chk(vout_target_out, SLOT_RST[S_VCMD]);
  endtask

  // Read-only write, ceiling overflow, range warnings
  task automatic t_ceiling();
    wr(CMD_FCEIL, 16'h1234);
    rd(CMD_FCEIL, FCEIL_VAL);
    rd(CMD_STAT_CML, 16'h0040);
    chk(alert_oe_out, 1'b1);
    wr(CMD_CLEAR, 16'h0000);
    chk(alert_oe_out, 1'b0);
    wr(SLOT_CMD[S_CEIL], 16'hFFFF);
    rd(SLOT_CMD[S_CEIL], FCEIL_VAL);
    rd(CMD_STAT_WORD, 16'h8002);
    rd(CMD_STAT_VOUT, 16'h0008);
    wr(SLOT_CMD[S_CEIL], RANGE1_LIM);
    wr(CMD_CLEAR, 16'h0000);
    range_sel_in = 1'b1;
    rd(CMD_STAT_VOUT, 16'h0000);
    wr(SLOT_CMD[S_CEIL], RANGE1_LIM + 16'h0001);
    rd(CMD_STAT_VOUT, 16'h0008);
  endtask

  // Clamping of command and margins
  task automatic t_clamp();
    settle();
    range_sel_in = 1'b0;
    wr(CMD_CLEAR, 16'h0000);
    wr(SLOT_CMD[S_VCMD], 16'h3000);
    rd(SLOT_CMD[S_VCMD], 16'h2C01);
    chk(vout_target_out, 16'h2C01);
    rd(CMD_STAT_WORD, 16'h8000);
    rd(CMD_STAT_VOUT, 16'h0008);
    wr(SLOT_CMD[S_VCMD], 16'h1000);
    wr(SLOT_CMD[S_MHI], 16'h1100);
    wr(SLOT_CMD[S_MLO], 16'h0F00);
    margin_hi_in = 1'b1;
    settle();
    chk(vout_target_out, 16'h1100);
    margin_hi_in = 1'b0;
    margin_lo_in = 1'b1;
    settle();
    chk(vout_target_out, 16'h0F00);
    margin_lo_in = 1'b0;
    wr(SLOT_CMD[S_MHI], 16'h2D00);
    rd(SLOT_CMD[S_MHI], 16'h2C01);
    wr(SLOT_CMD[S_CEIL], 16'h5800);
    wr(CMD_CLEAR, 16'h0000);
  endtask

  // Voltage warnings and faults
  task automatic t_volt();
    vsense_in = 16'h1150;
    settle();
    chk(ov_fault_out, 1'b0);
    chk(alert_oe_out, 1'b1);
    rd(CMD_STAT_VOUT, 16'h0040);
    wr(SLOT_CMD[S_MASK], 16'h00FF);
    chk(alert_oe_out, 1'b0);
    wr(SLOT_CMD[S_MASK], 16'h0000);
    settle();
    vsense_in = 16'h119B;
    settle();
    chk(ov_fault_out, 1'b1);
    vsense_in = 16'h1000;
    settle();
    chk(ov_fault_out, 1'b0);
    rd(CMD_STAT_VOUT, 16'h00C0);
    wr(CMD_STAT_VOUT, 16'h00C0);
    rd(CMD_STAT_VOUT, 16'h0000);
    settle();
    vsense_in = 16'h0E65;
    settle();
    chk(uv_fault_out, 1'b1);
    rd(CMD_STAT_VOUT, 16'h0030);
    settle();
    chan_on_in = 1'b0;
    settle();
    chk(uv_fault_out, 1'b0);
    chan_on_in = 1'b1;
    vsense_in = 16'h0E66;
    settle();
    chk(uv_fault_out, 1'b0);
    vsense_in = 16'h1000;
    wr(CMD_CLEAR, 16'h0000);
  endtask

  // Common flags while a new trip level settles
  task automatic t_common();
    wr(SLOT_CMD[S_OVF], SLOT_RST[S_OVF]);
    rd(CMD_COMMON, 16'h0000);
    repeat (SETTLE) @(negedge core_clk_in);
    rd(CMD_COMMON, {8'h00, COMMON_OK});
  endtask

  // Load line against servo
  task automatic t_llp();
    chk(servo_on_out, 1'b1);
    wr(SLOT_CMD[S_LLP], 16'hE00A);
    chk(servo_on_out, 1'b0);
    chk(llp_pct_out, 16'hE00A);
    chk(llp_full_scale_out, SLOT_RST[S_OCW]);
    chk(vout_target_out, 16'h1000);
    wr(SLOT_CMD[S_OCW], 16'hDA90);
    chk(llp_full_scale_out, 16'hDA90);
    wr(SLOT_CMD[S_OCW], SLOT_RST[S_OCW]);
    wr(SLOT_CMD[S_LLP], 16'h0000);
    chk(llp_on_out, 1'b0);
    chk(servo_on_out, 1'b1);
  endtask

  // Sense resistance, trip code, current faults and warnings
  task automatic t_iout();
    chk(rsense_out, SLOT_RST[S_RSNS]);
    chk(oc_code_out, 8'h2F);
    temp_in = 16'h007F;
    settle();
    chk(rsense_out > SLOT_RST[S_RSNS], 1'b1);
    wr(SLOT_CMD[S_TEMPCO], 16'hF0C4);
    chk(rsense_out < SLOT_RST[S_RSNS], 1'b1);
    temp_in = 16'h001B;
    wr(SLOT_CMD[S_TEMPCO], SLOT_RST[S_TEMPCO]);
    wr(SLOT_CMD[S_OCF], 16'h0BFF);
    chk(oc_code_out, OC_CODE_MAX);
    wr(SLOT_CMD[S_OCF], SLOT_RST[S_OCF]);
    rise_ramp_in = 1'b1;
    iout_in = 16'hDAA0;
    isense_in = 8'h30;
    settle();
    chk(oc_fault_out, 1'b0);
    rd(CMD_STAT_IOUT, 16'h0000);
    settle();
    rise_ramp_in = 1'b0;
    fall_ramp_in = 1'b1;
    settle();
    chk(oc_fault_out, 1'b0);
    fall_ramp_in = 1'b0;
    settle();
    chk(oc_fault_out, 1'b1);
    rd(CMD_STAT_IOUT, 16'h00A0);
    rd(CMD_STAT_WORD, 16'h4000);
    settle();
    iout_in = 16'hD000;
    isense_in = 8'h2F;
    settle();
    chk(oc_fault_out, 1'b0);
    wr(CMD_STAT_IOUT, 16'h00A0);
    chk(alert_oe_out, 1'b0);
  endtask

  // Main sequence
  initial begin
    fork
      host_u.idle(2);
    join_none
    repeat (2) @(negedge core_clk_in);
    nrst_in = 1'b1;
    repeat (2) @(negedge core_clk_in);
    host_u.idle(4);
    t_defaults();
    t_ceiling();
    t_clamp();
    t_volt();
    t_common();
    t_llp();
    t_iout();
    finish_test();
  end
endmodule
